// ### port_function_pkg.sv
// Shared constants, types and helpers for the port function selection block
package port_function_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int          NUM_PORTS  = 20;
  localparam int          PORT_W     = 5;
  localparam int          DATA_W     = 16;
  localparam int          ADDR_W     = 8;
  localparam int          DAC_W      = 12;
  localparam int          CODE_MSB   = 15;
  localparam int          CODE_LSB   = 12;
  localparam int          HALF_SPLIT = 16;

  // ************************************************************
  // Function codes
  // ************************************************************
  localparam logic [3:0]  FUNC_HIZ       = 4'h0;
  localparam logic [3:0]  FUNC_THRESH_IN = 4'h1;
  localparam logic [3:0]  FUNC_XLATE     = 4'h2;
  localparam logic [PORT_W-1:0] LAST_PORT = 5'h13;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFF_MASK     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MODE     = 8'h12;
  localparam logic [ADDR_W-1:0] OFF_LEVEL    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EVENT    = 8'h16;
  localparam logic [ADDR_W-1:0] OFF_CFG_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_DAC_BASE = 8'h40;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [DATA_W-1:0]    CFG_RESET  = 16'h0000;
  localparam logic [DAC_W-1:0]     DAC_RESET  = 12'h000;
  localparam logic [NUM_PORTS-1:0] MASK_RESET = 20'hf_ffff;
  localparam logic [NUM_PORTS-1:0] MODE_RESET = 20'h0_0000;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 8;
  localparam int SETTLE_NS       = 1000000;
  localparam int SETTLE_CYCLES   = SETTLE_NS / CLK_PERIOD_NS;
  localparam int HIZ_HOLD_CYCLES = 16;
  localparam int XLATE_LOCKOUT   = 6;

  // ************************************************************
  // Host command set
  // ************************************************************
  typedef enum logic [1:0] {
    OP_WRITE     = 2'b00,
    OP_READ      = 2'b01,
    OP_SET_FUNC  = 2'b10,
    OP_ARM_INPUT = 2'b11
  } op_t;

  // Half of a 20-bit port vector as a 16-bit word
  function automatic logic [DATA_W-1:0] half16(input logic [NUM_PORTS-1:0] v, input logic hi);
    return hi ? {12'h000, v[NUM_PORTS-1:HALF_SPLIT]} : v[HALF_SPLIT-1:0];
  endfunction

  // Address falls in a per-port register bank
  function automatic logic in_bank(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base);
    return (addr >= base) && (addr < base + ADDR_W'(NUM_PORTS));
  endfunction

  // Port index within a per-port register bank
  function automatic logic [PORT_W-1:0] bank_index(input logic [ADDR_W-1:0] addr,
                                                   input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = addr - base;
    return d[PORT_W-1:0];
  endfunction

endpackage

// ### port_function_link.sv
// Register link between host controller and port device
`timescale 1ns/1ns
interface port_function_link (
  input wire logic mclk,
  input wire logic srst
);
  import port_function_pkg::*;

  logic              req_valid;
  logic              req_ready;
  logic              req_write;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_rdata;

  modport device (
    input  mclk, srst, req_valid, req_write, req_addr, req_wdata,
    output req_ready, rsp_valid, rsp_rdata
  );

  modport host (
    input  mclk, srst, req_ready, rsp_valid, rsp_rdata,
    output req_valid, req_write, req_addr, req_wdata
  );
endinterface

// ### port_function_device.sv
// Device end: per-port function codes, threshold inputs, event flags, translator pairs
`timescale 1ns/1ns

// How it works
// R1: Code in bits 15:12 selects each port
// R2: Host passes through high impedance first
// R3: Code 0000 drives nothing, senses nothing
// R4: Code 0001 compares against port DAC value
// R5: Above threshold reads one, else zero
// R6: Host masks events before writing threshold
// R7: Host waits 1ms, then sets event mode
// R8: Events detected only once mask cleared
// R9: Comparison result readable as readback bit
// R10: Code 0010 joins port with next port
// R11: Lower port code enables pair; upper hi-Z
// R12: Host never puts port 19 in translator
// R13: Translator ports observed through input path
// R14: Code changes only on complete write
module port_function_device (
  port_function_link.device              link,
  input  wire logic [port_function_pkg::DAC_W-1:0]     port_voltage [port_function_pkg::NUM_PORTS],
  output logic      [port_function_pkg::NUM_PORTS-1:0] pin_out,
  output logic      [port_function_pkg::NUM_PORTS-1:0] pin_oe,
  output logic      [port_function_pkg::NUM_PORTS-1:0] port_hiz
);
  import port_function_pkg::*;

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [DATA_W-1:0]    port_function_config [NUM_PORTS];
  logic [DAC_W-1:0]     dac_data             [NUM_PORTS];
  logic [NUM_PORTS-1:0] input_event_mask;
  logic [NUM_PORTS-1:0] input_event_mode;
  logic [NUM_PORTS-1:0] input_level_readback;
  logic [NUM_PORTS-1:0] event_status;

  logic                 wr;
  logic                 cfg_hit;
  logic                 dac_hit;
  logic [PORT_W-1:0]    reg_idx_cfg;
  logic [PORT_W-1:0]    reg_idx_dac;
  logic [NUM_PORTS-1:0] event_clear;
  logic [DATA_W-1:0]    next_rdata;

  // ************************************************************
  // Port decode
  // ************************************************************
  logic [3:0]           port_function_code [NUM_PORTS];
  logic [NUM_PORTS-1:0] is_thresh;
  logic [NUM_PORTS-1:0] is_pair_low;
  logic [NUM_PORTS-1:0] is_pair_high;
  logic [NUM_PORTS-1:0] sense_en;
  logic [NUM_PORTS-1:0] raw_above;

  // ************************************************************
  // Input synchroniser and events
  // ************************************************************
  logic [NUM_PORTS-1:0] sync1;
  logic [NUM_PORTS-1:0] sync2;
  logic [NUM_PORTS-1:0] sync3;
  logic [NUM_PORTS-1:0] level;
  logic [NUM_PORTS-1:0] level_prev;
  logic [NUM_PORTS-1:0] event_hit;

  // ************************************************************
  // Translator pair state
  // ************************************************************
  logic [NUM_PORTS-1:0] xl_up;
  logic [NUM_PORTS-1:0] xl_dn;
  logic [2:0]           xl_lock [NUM_PORTS];

  assign link.req_ready = 1'b1;
  assign wr             = link.req_valid && link.req_write;
  assign cfg_hit        = in_bank(link.req_addr, OFF_CFG_BASE);
  assign dac_hit        = in_bank(link.req_addr, OFF_DAC_BASE);
  assign reg_idx_cfg    = bank_index(link.req_addr, OFF_CFG_BASE);
  assign reg_idx_dac    = bank_index(link.req_addr, OFF_DAC_BASE);

  // ************************************************************
  // Configuration and threshold registers
  // ************************************************************
  // R14: whole word commit
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        port_function_config[i] <= CFG_RESET;
      end
    end else if (wr && cfg_hit) begin
      port_function_config[reg_idx_cfg] <= link.req_wdata;
    end
  end

  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        dac_data[i] <= DAC_RESET;
      end
    end else if (wr && dac_hit) begin
      dac_data[reg_idx_dac] <= link.req_wdata[DAC_W-1:0];
    end
  end

  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      input_event_mask <= MASK_RESET;
      input_event_mode <= MODE_RESET;
    end else if (wr) begin
      if (link.req_addr == OFF_MASK) begin
        input_event_mask[HALF_SPLIT-1:0] <= link.req_wdata;
      end
      if (link.req_addr == OFF_MASK + 8'h01) begin
        input_event_mask[NUM_PORTS-1:HALF_SPLIT] <= link.req_wdata[3:0];
      end
      if (link.req_addr == OFF_MODE) begin
        input_event_mode[HALF_SPLIT-1:0] <= link.req_wdata;
      end
      if (link.req_addr == OFF_MODE + 8'h01) begin
        input_event_mode[NUM_PORTS-1:HALF_SPLIT] <= link.req_wdata[3:0];
      end
    end
  end

  // Write one clears the event flags
  always_comb begin
    event_clear = '0;
    if (wr && link.req_addr == OFF_EVENT) begin
      event_clear[HALF_SPLIT-1:0] = link.req_wdata;
    end
    if (wr && link.req_addr == OFF_EVENT + 8'h01) begin
      event_clear[NUM_PORTS-1:HALF_SPLIT] = link.req_wdata[3:0];
    end
  end

  // ************************************************************
  // Function decode and comparators
  // ************************************************************
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      // R1: code field
      port_function_code[i] = port_function_config[i][CODE_MSB:CODE_LSB];
      is_thresh[i]          = port_function_code[i] == FUNC_THRESH_IN;
      // R10: pair from lower port
      is_pair_low[i]        = (port_function_code[i] == FUNC_XLATE) && (i < NUM_PORTS - 1);
      // R4: threshold from own DAC register
      // R5: strictly above reads one
      raw_above[i]          = port_voltage[i] > dac_data[i];
    end
    // R11: upper port follows lower code only
    is_pair_high = {is_pair_low[NUM_PORTS-2:0], 1'b0};
    // R3: unselected ports sense nothing
    // R13: translator ports keep input path
    sense_en = is_thresh | is_pair_low | is_pair_high;
  end

  // Three stage synchroniser, accepted when last two agree
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
    end else begin
      sync1 <= raw_above;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (sync2[i] == sync3[i]) begin
          level[i] <= sync2[i];
        end
      end
    end
  end

  // R9: comparison result readback
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      input_level_readback <= '0;
    end else begin
      input_level_readback <= level & sense_en;
    end
  end

  // R8: events only while unmasked
  assign event_hit = (input_level_readback ^ level_prev) & input_event_mode & ~input_event_mask & sense_en;

  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      level_prev   <= '0;
      event_status <= '0;
    end else begin
      level_prev   <= input_level_readback;
      event_status <= (event_status & ~event_clear) | event_hit;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    next_rdata = '0;
    if (cfg_hit) begin
      next_rdata = port_function_config[reg_idx_cfg];
    end else if (dac_hit) begin
      next_rdata = {4'h0, dac_data[reg_idx_dac]};
    end else begin
      unique case (link.req_addr)
        OFF_MASK:          next_rdata = half16(input_event_mask, 1'b0);
        OFF_MASK + 8'h01:  next_rdata = half16(input_event_mask, 1'b1);
        OFF_MODE:          next_rdata = half16(input_event_mode, 1'b0);
        OFF_MODE + 8'h01:  next_rdata = half16(input_event_mode, 1'b1);
        OFF_LEVEL:         next_rdata = half16(input_level_readback, 1'b0);
        OFF_LEVEL + 8'h01: next_rdata = half16(input_level_readback, 1'b1);
        OFF_EVENT:         next_rdata = half16(event_status, 1'b0);
        OFF_EVENT + 8'h01: next_rdata = half16(event_status, 1'b1);
        default:           next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      link.rsp_valid <= 1'b0;
      link.rsp_rdata <= '0;
    end else begin
      link.rsp_valid <= link.req_valid && !link.req_write;
      if (link.req_valid && !link.req_write) begin
        link.rsp_rdata <= next_rdata;
      end
    end
  end

  // ************************************************************
  // Translator pairs
  // ************************************************************
  // R10: open-drain low mirrored across pair
  // Lockout stops the lagging side latching the pair low
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      xl_up <= '0;
      xl_dn <= '0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        xl_lock[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_PORTS - 1; i++) begin
        if (!is_pair_low[i]) begin
          xl_up[i]   <= 1'b0;
          xl_dn[i]   <= 1'b0;
          xl_lock[i] <= '0;
        end else if (xl_up[i]) begin
          if (level[i]) begin
            xl_up[i]   <= 1'b0;
            xl_lock[i] <= 3'(XLATE_LOCKOUT);
          end
        end else if (xl_dn[i]) begin
          if (level[i+1]) begin
            xl_dn[i]   <= 1'b0;
            xl_lock[i] <= 3'(XLATE_LOCKOUT);
          end
        end else if (xl_lock[i] != 3'h0) begin
          xl_lock[i] <= xl_lock[i] - 3'h1;
        end else if (!level[i]) begin
          xl_up[i] <= 1'b1;
        end else if (!level[i+1]) begin
          xl_dn[i] <= 1'b1;
        end
      end
      xl_up[NUM_PORTS-1]   <= 1'b0;
      xl_dn[NUM_PORTS-1]   <= 1'b0;
      xl_lock[NUM_PORTS-1] <= '0;
    end
  end

  // R3: high impedance drives nothing
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      pin_oe   <= '0;
      port_hiz <= '1;
    end else begin
      pin_oe   <= {xl_up[NUM_PORTS-2:0], 1'b0} | xl_dn;
      port_hiz <= ~sense_en;
    end
  end

  assign pin_out = '0;

endmodule

// ### port_function_host.sv
// Host end: raw register access plus ordered function change and input arming sequences
`timescale 1ns/1ns
module port_function_host #(
  parameter int SETTLE_CYCLES   = port_function_pkg::SETTLE_CYCLES,
  parameter int HIZ_HOLD_CYCLES = port_function_pkg::HIZ_HOLD_CYCLES
) (
  port_function_link.host                           link,
  input  wire logic                                 cmd_valid,
  output logic                                      cmd_ready,
  input  wire port_function_pkg::op_t               cmd_op,
  input  wire logic [port_function_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [port_function_pkg::PORT_W-1:0] cmd_port,
  input  wire logic [port_function_pkg::DATA_W-1:0] cmd_data,
  output logic                                      res_valid,
  output logic                                      res_error,
  output logic      [port_function_pkg::DATA_W-1:0] res_data
);
  import port_function_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE     = 4'h0,
    H_RAW_WR   = 4'h1,
    H_RAW_RD   = 4'h2,
    H_RD_WAIT  = 4'h3,
    H_HIZ      = 4'h4,
    H_HOLD     = 4'h5,
    H_PARTNER  = 4'h6,
    H_FUNC     = 4'h7,
    H_MASK_SET = 4'h8,
    H_DAC      = 4'h9,
    H_SETTLE   = 4'ha,
    H_MODE     = 4'hb,
    H_UNMASK   = 4'hc,
    H_DONE     = 4'hd
  } host_state_t;

  host_state_t          state;
  logic [ADDR_W-1:0]    addr_q;
  logic [PORT_W-1:0]    port_q;
  logic [DATA_W-1:0]    data_q;
  logic [NUM_PORTS-1:0] mask_shadow;
  logic [NUM_PORTS-1:0] mode_shadow;
  logic [NUM_PORTS-1:0] port_bit;
  logic [17:0]          wait_cnt;
  logic                 taken;
  logic                 bad_func;

  assign port_bit  = NUM_PORTS'(1) << port_q;
  assign taken     = link.req_valid && link.req_ready;
  assign cmd_ready = state == H_IDLE;
  // R12: no translator on last port
  assign bad_func  = (cmd_port > LAST_PORT) ||
                     ((cmd_data[CODE_MSB:CODE_LSB] == FUNC_XLATE) && (cmd_port == LAST_PORT));

  // ************************************************************
  // Request per state
  // ************************************************************
  always_comb begin
    link.req_valid = 1'b1;
    link.req_write = 1'b1;
    link.req_addr  = '0;
    link.req_wdata = '0;
    unique case (state)
      H_RAW_WR: begin
        link.req_addr  = addr_q;
        link.req_wdata = data_q;
      end
      H_RAW_RD: begin
        link.req_write = 1'b0;
        link.req_addr  = addr_q;
      end
      // R2: pass through high impedance
      H_HIZ: begin
        link.req_addr  = OFF_CFG_BASE + ADDR_W'(port_q);
        link.req_wdata = CFG_RESET;
      end
      // R11: upper port kept high impedance
      H_PARTNER: begin
        link.req_addr  = OFF_CFG_BASE + ADDR_W'(port_q) + 8'h01;
        link.req_wdata = CFG_RESET;
      end
      H_FUNC: begin
        link.req_addr  = OFF_CFG_BASE + ADDR_W'(port_q);
        link.req_wdata = data_q;
      end
      // R6: mask before threshold
      H_MASK_SET: begin
        link.req_addr  = OFF_MASK + ADDR_W'(port_q[4]);
        link.req_wdata = half16(mask_shadow | port_bit, port_q[4]);
      end
      H_DAC: begin
        link.req_addr  = OFF_DAC_BASE + ADDR_W'(port_q);
        link.req_wdata = {4'h0, data_q[DAC_W-1:0]};
      end
      H_MODE: begin
        link.req_addr  = OFF_MODE + ADDR_W'(port_q[4]);
        link.req_wdata = half16(mode_shadow | port_bit, port_q[4]);
      end
      // R8: unmask after mode set
      H_UNMASK: begin
        link.req_addr  = OFF_MASK + ADDR_W'(port_q[4]);
        link.req_wdata = half16(mask_shadow & ~port_bit, port_q[4]);
      end
      default: begin
        link.req_valid = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      state     <= H_IDLE;
      addr_q    <= '0;
      port_q    <= '0;
      data_q    <= '0;
      wait_cnt  <= '0;
      res_valid <= 1'b0;
      res_error <= 1'b0;
      res_data  <= '0;
    end else begin
      res_valid <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (cmd_valid) begin
            addr_q    <= cmd_addr;
            port_q    <= cmd_port;
            data_q    <= cmd_data;
            res_error <= 1'b0;
            unique case (cmd_op)
              OP_WRITE:     state <= H_RAW_WR;
              OP_READ:      state <= H_RAW_RD;
              OP_SET_FUNC:  state <= bad_func ? H_DONE : H_HIZ;
              OP_ARM_INPUT: state <= (cmd_port > LAST_PORT) ? H_DONE : H_MASK_SET;
            endcase
            if ((cmd_op == OP_SET_FUNC && bad_func) || (cmd_op == OP_ARM_INPUT && cmd_port > LAST_PORT)) begin
              res_error <= 1'b1;
            end
          end
        end
        H_RAW_WR: if (taken) state <= H_DONE;
        H_RAW_RD: if (taken) state <= H_RD_WAIT;
        H_RD_WAIT: begin
          if (link.rsp_valid) begin
            res_data <= link.rsp_rdata;
            state    <= H_DONE;
          end
        end
        H_HIZ: if (taken) begin
          wait_cnt <= 18'(HIZ_HOLD_CYCLES);
          state    <= H_HOLD;
        end
        H_HOLD: begin
          if (wait_cnt > 18'h1) begin
            wait_cnt <= wait_cnt - 18'h1;
          end else begin
            state <= (data_q[CODE_MSB:CODE_LSB] == FUNC_XLATE) ? H_PARTNER : H_FUNC;
          end
        end
        H_PARTNER: if (taken) state <= H_FUNC;
        H_FUNC:    if (taken) state <= H_DONE;
        H_MASK_SET: if (taken) state <= H_DAC;
        H_DAC: if (taken) begin
          wait_cnt <= 18'(SETTLE_CYCLES);
          state    <= H_SETTLE;
        end
        // R7: threshold settle time
        H_SETTLE: begin
          if (wait_cnt > 18'h1) begin
            wait_cnt <= wait_cnt - 18'h1;
          end else begin
            state <= H_MODE;
          end
        end
        H_MODE:   if (taken) state <= H_UNMASK;
        H_UNMASK: if (taken) state <= H_DONE;
        H_DONE: begin
          res_valid <= 1'b1;
          state     <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Shadows of mask and mode, host is their only writer
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      mask_shadow <= MASK_RESET;
      mode_shadow <= MODE_RESET;
    end else if (taken && link.req_write) begin
      if (link.req_addr == OFF_MASK) mask_shadow[HALF_SPLIT-1:0] <= link.req_wdata;
      if (link.req_addr == OFF_MASK + 8'h01) mask_shadow[NUM_PORTS-1:HALF_SPLIT] <= link.req_wdata[3:0];
      if (link.req_addr == OFF_MODE) mode_shadow[HALF_SPLIT-1:0] <= link.req_wdata;
      if (link.req_addr == OFF_MODE + 8'h01) mode_shadow[NUM_PORTS-1:HALF_SPLIT] <= link.req_wdata[3:0];
    end
  end

endmodule

// ### port_function_link_monitor.sv
// Checker on the register link between host and device ends
`timescale 1ns/1ns
module port_function_link_monitor
  import port_function_pkg::*;
(
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_rdata
);
  logic [ADDR_W-1:0] cfg_a;
  logic [DATA_W-1:0] cfg_d;

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  sequence rd_s;
    req_valid && req_ready && !req_write;
  endsequence
  sequence cfg_wr_s;
    req_valid && req_write && in_bank(req_addr, OFF_CFG_BASE);
  endsequence

  // ****
  // Last config write
  // ****
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_a <= 8'h00;
      cfg_d <= 16'h0000;
    end else if (req_valid && req_write && in_bank(req_addr, OFF_CFG_BASE)) begin
      cfg_a <= req_addr;
      cfg_d <= req_wdata;
    end
  end

  AST_READ_ANSWER: assert property (rd_s |=> rsp_valid)
    else $error("read without answer");
  AST_ANSWER_CAUSE: assert property (rsp_valid |-> $past(req_valid && !req_write))
    else $error("answer without read");
  AST_RDATA_HOLD: assert property (rsp_valid ##1 !rsp_valid |-> $stable(rsp_rdata))
    else $error("read data moved");
  AST_UNMAPPED_ZERO: assert property (rd_s and req_addr == 8'h00 |=> rsp_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_UPPER_HALF: assert property (rd_s and req_addr[7:3] == 5'h02 and req_addr[0] |=> rsp_rdata[15:4] == 12'h000)
    else $error("upper half bits set");
  AST_NO_PAIR_19: assert property (cfg_wr_s |-> !(req_addr == 8'h33 && req_wdata[15:12] == FUNC_XLATE))
    else $error("translator code on last port");
  AST_CFG_READBACK: assert property (rd_s and req_addr == cfg_a |=> rsp_rdata == $past(cfg_d))
    else $error("config readback differs");
  AST_DAC_WIDTH: assert property (rd_s and in_bank(req_addr, OFF_DAC_BASE) |=> rsp_rdata[15:12] == 4'h0)
    else $error("threshold wider than twelve bits");
endmodule

// ### test_port_function_mode_select.sv
// Testbench joining host and device ends over the register link
`timescale 1ns/1ns
module test_port_function_mode_select;
  import port_function_pkg::*;
  logic                 mclk = 1'b0;
  logic                 srst = 1'b1;
  logic                 cmd_valid = 1'b0;
  logic                 cmd_ready;
  logic                 res_valid;
  logic                 res_error;
  op_t                  cmd_op = OP_READ;
  logic [ADDR_W-1:0]    cmd_addr = 8'h00;
  logic [PORT_W-1:0]    cmd_port = 5'h00;
  logic [DATA_W-1:0]    cmd_data = 16'h0000;
  logic [DATA_W-1:0]    res_data;
  logic [NUM_PORTS-1:0] pin_oe;
  logic [NUM_PORTS-1:0] pin_out;
  logic [NUM_PORTS-1:0] port_hiz;
  logic [DAC_W-1:0]     ext [NUM_PORTS];
  logic [DAC_W-1:0]     pv [NUM_PORTS];
  int                   n_fail = 0;
  int                   checks_done = 0;

  always #4 mclk = ~mclk;
  // Open-drain wire: a pulled pin reads zero
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) pv[i] = pin_oe[i] ? 12'h000 : ext[i];
  end

  port_function_link port_function_link_i (.mclk(mclk), .srst(srst));
  port_function_device port_function_device_i (.link(port_function_link_i.device), .port_voltage(pv),
    .pin_out(pin_out), .pin_oe(pin_oe), .port_hiz(port_hiz));
  port_function_host #(.SETTLE_CYCLES(20), .HIZ_HOLD_CYCLES(2)) port_function_host_i (
    .link(port_function_link_i.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_port(cmd_port), .cmd_data(cmd_data), .res_valid(res_valid),
    .res_error(res_error), .res_data(res_data));
  port_function_link_monitor port_function_link_monitor_i (.mclk(mclk), .srst(srst),
    .req_valid(port_function_link_i.req_valid), .req_ready(port_function_link_i.req_ready),
    .req_write(port_function_link_i.req_write), .req_addr(port_function_link_i.req_addr),
    .req_wdata(port_function_link_i.req_wdata), .rsp_valid(port_function_link_i.rsp_valid),
    .rsp_rdata(port_function_link_i.rsp_rdata));

  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One host command, waits for its result pulse
  task automatic run(input op_t op, input logic [7:0] a, input logic [4:0] p, input logic [15:0] d);
    int n;
    n = 0;
    cmd_op = op;
    cmd_addr = a;
    cmd_port = p;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge mclk);
    chk("command taken", 20'h0, 20'(cmd_ready));
    cmd_valid = 1'b0;
    while (res_valid !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 300) begin
        n_fail++;
        finish_test();
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [19:0] exp, input string name);
    run(OP_READ, a, 5'h00, 16'h0000);
    chk(name, exp, 20'(res_data));
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  initial begin
    foreach (ext[i]) ext[i] = 12'h000;
    idle(10);
    srst = 1'b0;
    rd(8'h10, 20'h0_ffff, "mask low");
    rd(8'h11, 20'h0_000f, "mask high");
    rd(8'h12, 20'h0_0000, "mode low");
    rd(8'h20, 20'h0_0000, "config 0");
    rd(8'h00, 20'h0_0000, "unmapped");
    chk("hiz after reset", 20'hf_ffff, port_hiz);
    run(OP_SET_FUNC, 8'h00, 5'h03, 16'h1000);
    rd(8'h23, 20'h0_1000, "config 3");
    run(OP_ARM_INPUT, 8'h00, 5'h03, 16'h0800);
    rd(8'h43, 20'h0_0800, "threshold 3");
    rd(8'h12, 20'h0_0008, "mode armed");
    rd(8'h10, 20'h0_fff7, "mask armed");
    run(OP_SET_FUNC, 8'h00, 5'h05, 16'h1000);
    ext[3] = 12'h801;
    ext[4] = 12'hfff;
    ext[5] = 12'h001;
    idle(12);
    rd(8'h14, 20'h0_0028, "level above");
    rd(8'h16, 20'h0_0008, "event armed only");
    ext[3] = 12'h800;
    idle(12);
    rd(8'h14, 20'h0_0020, "level at threshold");
    run(OP_WRITE, 8'h16, 5'h00, 16'h0008);
    rd(8'h16, 20'h0_0000, "event cleared");
    chk("hiz inputs", 20'hf_ffd7, port_hiz);
    run(OP_SET_FUNC, 8'h00, 5'h13, 16'h2000);
    chk("refuse last port", 20'h1, 20'(res_error));
    rd(8'h33, 20'h0_0000, "config 19");
    run(OP_SET_FUNC, 8'h00, 5'h14, 16'h1000);
    chk("refuse port 20", 20'h1, 20'(res_error));
    ext[6] = 12'h100;
    ext[7] = 12'h100;
    run(OP_SET_FUNC, 8'h00, 5'h06, 16'h2000);
    rd(8'h27, 20'h0_0000, "pair upper");
    idle(12);
    chk("pair idle", 20'h0_0000, pin_oe);
    ext[6] = 12'h000;
    idle(12);
    chk("pair drives", 20'h0_0080, pin_oe);
    rd(8'h14, 20'h0_0020, "pair low");
    ext[6] = 12'h100;
    idle(20);
    chk("pair released", 20'h0_0000, pin_oe);
    rd(8'h14, 20'h0_00e0, "pair high");
    ext[7] = 12'h000;
    idle(12);
    chk("pair drives lower", 20'h0_0040, pin_oe);
    ext[7] = 12'h100;
    idle(20);
    chk("pair lower released", 20'h0_0000, pin_oe);
    chk("pin level", 20'h0_0000, pin_out);
    chk("hiz pair", 20'hf_ff17, port_hiz);
    finish_test();
  end
endmodule
